// file: rtl/lfvf_engine.sv
// Layer-2 forwarding engine with station learning, aging, VLAN filter, port blocking
`timescale 1ns/1ps
module lfvf_engine #(
   parameter int unsigned DEPTH       = 256,
   parameter int unsigned NVLAN       = 4,
   parameter int unsigned TICK_CYCLES = lfvf_pkg::TICK_CYCLES,
   parameter int unsigned FWD_DELAY_S = lfvf_pkg::FWD_DELAY_S
) (
   input  wire logic                       core_clk_i,
   input  wire logic                       resetn_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [7:0]                 wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   input  wire logic                       frame_valid_i,
   input  wire lfvf_pkg::lfvf_hdr_t        frame_i,
   output logic                            frame_ready_o,
   output logic                            dec_valid_o,
   output lfvf_pkg::lfvf_dec_t             dec_o,
   input  wire logic [lfvf_pkg::NPORT-1:0] link_up_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam int unsigned NP = lfvf_pkg::NPORT;
   localparam int unsigned VW = (NVLAN > 1) ? $clog2(NVLAN) : 1;
   localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
   localparam int unsigned EW = $bits(lfvf_pkg::lfvf_ent_t);
   localparam int unsigned IG = lfvf_pkg::MAC_IG_BIT;

   typedef enum logic [2:0] {
      S_CLR    = 3'h0,
      S_IDLE   = 3'h1,
      S_DCHK   = 3'h2,
      S_SCHK   = 3'h3,
      S_AGE_RD = 3'h4,
      S_AGE_WR = 3'h5,
      S_CMD    = 3'h6
   } lfvf_state_t;

   function automatic logic [AW-1:0] hash_f(input logic [47:0] mac);
      logic [AW-1:0] h;
      h = '0;
      for (int i = 0; i < 48; i += AW) begin
         h = h ^ AW'(mac >> i);
      end
      return h;
   endfunction

   function automatic logic [31:0] be_f(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [19:0] clamp_f(input logic [31:0] v);
      logic [19:0] r;
      r = 20'(v);
      if (v < 32'(lfvf_pkg::AGE_MIN_S)) begin
         r = lfvf_pkg::AGE_MIN_S;
      end else if (v > 32'(lfvf_pkg::AGE_MAX_S)) begin
         r = lfvf_pkg::AGE_MAX_S;
      end
      return r;
   endfunction

   lfvf_state_t          state_reg, state_next;
   lfvf_pkg::lfvf_ent_t  rd, wd;
   logic [EW-1:0]        rd_raw;
   logic [AW-1:0]        idx_reg, mem_addr;
   logic                 mem_we;
   logic [1:0]           ctrl_reg;
   logic [19:0]          age_reg;
   logic [NP-1:0]        prim_reg, stby_reg, dplx_reg, edge_reg, blk_reg, link_reg;
   logic [VW-1:0]        vsel_reg;
   logic [4:0]           psel_reg, cport_reg;
   logic [47:0]          cmac_reg, dst_reg, src_reg;
   logic                 cadd_reg, cmd_pend, age_pend, cmd_pend_next, age_pend_next;
   logic [11:0]          vid_tab [NVLAN];
   logic [NP-1:0]        vmem_tab [NVLAN], vunt_tab [NVLAN], vm_sel [NVLAN], vu_sel [NVLAN];
   logic [11:0]          pvid_reg [NP];
   logic [11:0]          vid_reg, pvid_sel;
   logic [4:0]           port_reg;
   logic                 fctl_reg, wr, fr_take, sec_tick, prim_up, legacy_ok;
   logic [CW-1:0]        tick_cnt;
   logic [15:0]          fail_cnt;
   logic [NP-1:0]        vmem, vunt, pbit, dbit, elig, fwd;
   logic                 ing_ok, hit, learn;
   logic [31:0]          rd_mux;

   ////////////////////////////////////////////////////////////////////////////////
   // Register bus

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ctrl_reg  <= '0;
         age_reg   <= lfvf_pkg::AGE_DEF_S;
         prim_reg  <= '0;
         stby_reg  <= '0;
         dplx_reg  <= '0;
         edge_reg  <= '0;
         vsel_reg  <= '0;
         psel_reg  <= '0;
         cmac_reg  <= '0;
         cport_reg <= '0;
         cadd_reg  <= 1'b0;
      end else if (wr) begin
         case (wb_adr_i)
            lfvf_pkg::OFS_CTRL:  ctrl_reg <= 2'(be_f(32'(ctrl_reg), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_AGE:   age_reg <= clamp_f(be_f(32'(age_reg), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_PRIM:  prim_reg <= NP'(be_f(32'(prim_reg), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_STBY:  stby_reg <= NP'(be_f(32'(stby_reg), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_DPLX:  dplx_reg <= NP'(be_f(32'(dplx_reg), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_EDGE:  edge_reg <= NP'(be_f(32'(edge_reg), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_VSEL:  vsel_reg <= VW'(be_f(32'(vsel_reg), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_PSEL:  psel_reg <= 5'(be_f(32'(psel_reg), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_MACLO: cmac_reg[31:0] <= be_f(cmac_reg[31:0], wb_dat_i, wb_sel_i);
            lfvf_pkg::OFS_MACHI: cmac_reg[47:32] <= 16'(be_f(32'(cmac_reg[47:32]), wb_dat_i, wb_sel_i));
            lfvf_pkg::OFS_CMD: begin
               cport_reg <= wb_dat_i[4:0];
               cadd_reg  <= wb_dat_i[lfvf_pkg::CMD_ADD];
            end
            default: begin
            end
         endcase
      end
   end

   // VLAN slots; slot 0 holds VLAN 1 with every port as untagged member
   generate
      for (genvar s = 0; s < NVLAN; s++) begin : g_vlan
         always_ff @(posedge core_clk_i) begin
            if (!resetn_i) begin
               vid_tab[s]  <= (s == 0) ? lfvf_pkg::VID_DEFAULT : 12'h000;
               vmem_tab[s] <= (s == 0) ? {NP{1'b1}} : '0;
               vunt_tab[s] <= (s == 0) ? {NP{1'b1}} : '0;
            end else if (wr && vsel_reg == VW'(s)) begin
               if (wb_adr_i == lfvf_pkg::OFS_VID) begin
                  vid_tab[s] <= 12'(be_f(32'(vid_tab[s]), wb_dat_i, wb_sel_i));
               end
               if (wb_adr_i == lfvf_pkg::OFS_VMEM) begin
                  vmem_tab[s] <= NP'(be_f(32'(vmem_tab[s]), wb_dat_i, wb_sel_i));
               end
               if (wb_adr_i == lfvf_pkg::OFS_VUNT) begin
                  vunt_tab[s] <= NP'(be_f(32'(vunt_tab[s]), wb_dat_i, wb_sel_i));
               end
            end
         end
         // VID 0 marks a free slot and never matches
         assign vm_sel[s] = (vid_tab[s] == vid_reg && vid_reg != 12'h000) ? vmem_tab[s] : '0;
         assign vu_sel[s] = (vid_tab[s] == vid_reg && vid_reg != 12'h000) ? vunt_tab[s] : '0;
      end

      for (genvar p = 0; p < NP; p++) begin : g_port
         logic [2:0] sync;
         always_ff @(posedge core_clk_i) begin
            if (!resetn_i) begin
               pvid_reg[p] <= lfvf_pkg::VID_DEFAULT;
               sync        <= '0;
               link_reg[p] <= 1'b0;
               blk_reg[p]  <= 1'b0;
            end else begin
               if (wr && wb_adr_i == lfvf_pkg::OFS_PVID && psel_reg == 5'(p)) begin
                  pvid_reg[p] <= 12'(be_f(32'(pvid_reg[p]), wb_dat_i, wb_sel_i));
               end
               sync <= {sync[1:0], link_up_i[p]};
               if (sync[1] == sync[2]) begin
                  link_reg[p] <= sync[2];
               end
               // Edge ports in rapid mode never block; in rapid mode a full-duplex standby frees at once
               blk_reg[p] <= ctrl_reg[lfvf_pkg::CTRL_STP] & stby_reg[p]
                  & ~(ctrl_reg[lfvf_pkg::CTRL_RAPID] & edge_reg[p])
                  & ~(~prim_up & (legacy_ok | (ctrl_reg[lfvf_pkg::CTRL_RAPID] & dplx_reg[p])));
            end
         end
      end
   endgenerate

   always_comb begin
      vmem = '0;
      vunt = '0;
      for (int s = 0; s < NVLAN; s++) begin
         vmem = vmem | vm_sel[s];
         vunt = vunt | vu_sel[s];
      end
   end

   always_comb begin
      case (wb_adr_i)
         lfvf_pkg::OFS_CTRL:  rd_mux = 32'(ctrl_reg);
         lfvf_pkg::OFS_AGE:   rd_mux = 32'(age_reg);
         lfvf_pkg::OFS_PRIM:  rd_mux = 32'(prim_reg);
         lfvf_pkg::OFS_STBY:  rd_mux = 32'(stby_reg);
         lfvf_pkg::OFS_DPLX:  rd_mux = 32'(dplx_reg);
         lfvf_pkg::OFS_EDGE:  rd_mux = 32'(edge_reg);
         lfvf_pkg::OFS_VSEL:  rd_mux = 32'(vsel_reg);
         lfvf_pkg::OFS_VID:   rd_mux = 32'(vid_tab[vsel_reg]);
         lfvf_pkg::OFS_VMEM:  rd_mux = 32'(vmem_tab[vsel_reg]);
         lfvf_pkg::OFS_VUNT:  rd_mux = 32'(vunt_tab[vsel_reg]);
         lfvf_pkg::OFS_PSEL:  rd_mux = 32'(psel_reg);
         lfvf_pkg::OFS_PVID:  rd_mux = (psel_reg < 5'(NP)) ? 32'(pvid_reg[psel_reg]) : 32'h00000000;
         lfvf_pkg::OFS_MACLO: rd_mux = cmac_reg[31:0];
         lfvf_pkg::OFS_MACHI: rd_mux = 32'(cmac_reg[47:32]);
         lfvf_pkg::OFS_CMD:   rd_mux = 32'(cmd_pend);
         lfvf_pkg::OFS_BLK:   rd_mux = 32'(blk_reg);
         lfvf_pkg::OFS_LINK:  rd_mux = 32'(link_reg);
         default:             rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Second tick and failover timer

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         tick_cnt <= '0;
         sec_tick <= 1'b0;
         fail_cnt <= '0;
      end else begin
         sec_tick <= (tick_cnt == CW'(TICK_CYCLES - 1));
         tick_cnt <= (tick_cnt == CW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
         if (prim_up) begin
            fail_cnt <= '0;
         end else if (sec_tick && !legacy_ok) begin
            fail_cnt <= fail_cnt + 16'h0001;
         end
      end
   end

   assign prim_up   = |(prim_reg & link_reg);
   assign legacy_ok = (fail_cnt >= 16'(FWD_DELAY_S));

   ////////////////////////////////////////////////////////////////////////////////
   // Table sequencer

   // Set wins over clear so a tick or command in the hand-off cycle is kept
   always_comb begin
      cmd_pend_next = (wr && wb_adr_i == lfvf_pkg::OFS_CMD) | (cmd_pend & (state_next != S_CMD));
      age_pend_next = sec_tick | (age_pend & ~(state_reg == S_IDLE && state_next == S_AGE_RD));
   end

   assign fr_take  = frame_ready_o & frame_valid_i;
   assign pvid_sel = (frame_i.port < 5'(NP)) ? pvid_reg[frame_i.port] : 12'h000;

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_reg     <= S_CLR;
         idx_reg       <= '0;
         cmd_pend      <= 1'b0;
         age_pend      <= 1'b0;
         frame_ready_o <= 1'b0;
      end else begin
         state_reg     <= state_next;
         cmd_pend      <= cmd_pend_next;
         age_pend      <= age_pend_next;
         frame_ready_o <= (state_next == S_IDLE) & ~cmd_pend_next & ~age_pend_next;
         if (state_reg == S_CLR || state_reg == S_AGE_WR) begin
            idx_reg <= idx_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         dst_reg  <= '0;
         src_reg  <= '0;
         port_reg <= '0;
         vid_reg  <= '0;
         fctl_reg <= 1'b0;
      end else if (fr_take) begin
         dst_reg  <= frame_i.dst;
         src_reg  <= frame_i.src;
         port_reg <= frame_i.port;
         fctl_reg <= frame_i.ctl;
         // Only a single 8100 tag is classified; inner tags travel as payload
         vid_reg  <= (frame_i.etype == lfvf_pkg::TPID_VLAN) ? frame_i.tci[11:0]
                                                             : pvid_sel;
      end
   end

   always_comb begin
      pbit   = NP'(1) << port_reg;
      dbit   = NP'(1) << rd.port;
      ing_ok = |(pbit & vmem & ~blk_reg);
      hit    = rd.valid & (rd.mac == dst_reg) & ~dst_reg[IG];
      elig   = vmem & ~blk_reg & ~pbit;
      fwd    = '0;
      if (ing_ok && !fctl_reg) begin
         fwd = hit ? (elig & dbit) : elig;
      end
      learn  = |(pbit & ~blk_reg) & ~src_reg[IG] & ~(rd.valid & rd.stat);
   end

   assign rd = lfvf_pkg::lfvf_ent_t'(rd_raw);

   always_comb begin
      state_next = state_reg;
      mem_addr   = idx_reg;
      mem_we     = 1'b0;
      wd         = rd;
      unique case (state_reg)
         S_CLR: begin
            mem_we = 1'b1;
            wd     = '0;
            if (idx_reg == AW'(DEPTH - 1)) begin
               state_next = S_IDLE;
            end
         end
         S_IDLE: begin
            if (cmd_pend) begin
               state_next = S_CMD;
            end else if (age_pend) begin
               state_next = S_AGE_RD;
            end else if (fr_take) begin
               mem_addr   = hash_f(frame_i.dst);
               state_next = S_DCHK;
            end
         end
         S_DCHK: begin
            mem_addr   = hash_f(src_reg);
            state_next = S_SCHK;
         end
         S_SCHK: begin
            mem_addr   = hash_f(src_reg);
            mem_we     = learn;
            wd         = '{valid: 1'b1, stat: 1'b0, port: port_reg, age: 20'h00000, mac: src_reg};
            state_next = S_IDLE;
         end
         S_AGE_RD: begin
            state_next = S_AGE_WR;
         end
         S_AGE_WR: begin
            // Static entries are skipped; each sweep adds one second to learned ones
            mem_we = rd.valid & ~rd.stat;
            wd.age = 20'(rd.age + 20'h00001);
            if (20'(rd.age + 20'h00001) >= age_reg) begin
               wd.valid = 1'b0;
            end
            state_next = (idx_reg == AW'(DEPTH - 1)) ? S_IDLE : S_AGE_RD;
         end
         S_CMD: begin
            mem_addr   = hash_f(cmac_reg);
            mem_we     = 1'b1;
            wd         = '{valid: cadd_reg, stat: cadd_reg, port: cport_reg, age: 20'h00000, mac: cmac_reg};
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   lfvf_table_ram #(
      .WIDTH (EW),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_table (
      .core_clk_i (core_clk_i),
      .we_i       (mem_we),
      .addr_i     (mem_addr),
      .wdata_i    (wd),
      .rdata_o    (rd_raw)
   );

   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         dec_valid_o <= 1'b0;
         dec_o       <= '0;
      end else begin
         dec_valid_o <= (state_reg == S_DCHK);
         if (state_reg == S_DCHK) begin
            dec_o <= '{fwd: fwd, untag: vunt & fwd, vid: vid_reg, ctl: fctl_reg};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_take_untag;
      fr_take && frame_i.etype != lfvf_pkg::TPID_VLAN;
   endsequence
   sequence s_take_tag;
      fr_take && frame_i.etype == lfvf_pkg::TPID_VLAN;
   endsequence

   property p_untag_vid;
      s_take_untag |=> vid_reg == $past(pvid_sel);
   endproperty
   a_untag_vid: assert property (p_untag_vid) else $error("untagged frame missed port VID");
   property p_tag_vid;
      s_take_tag |=> vid_reg == $past(frame_i.tci[11:0]);
   endproperty
   a_tag_vid: assert property (p_tag_vid) else $error("tag VID not taken");
   property p_hit_one;
      (s_take_tag or s_take_untag) ##1 (state_reg == S_DCHK && hit) ##1 dec_valid_o |-> $onehot0(dec_o.fwd);
   endproperty
   a_hit_one: assert property (p_hit_one) else $error("known station sent to several ports");
   property p_flood;
      (state_reg == S_DCHK && !hit && ing_ok && !fctl_reg) |=> dec_valid_o && dec_o.fwd == $past(elig);
   endproperty
   a_flood: assert property (p_flood) else $error("miss not flooded to members");
   property p_member;
      (state_reg == S_DCHK) |=> (dec_o.fwd & ~$past(vmem)) == '0;
   endproperty
   a_member: assert property (p_member) else $error("frame sent outside its VLAN");
   property p_blocked;
      (state_reg == S_DCHK) |=> (dec_o.fwd & $past(blk_reg)) == '0;
   endproperty
   a_blocked: assert property (p_blocked) else $error("data sent on blocked port");
   property p_ingress;
      (state_reg == S_DCHK && !ing_ok) |=> dec_o.fwd == '0;
   endproperty
   a_ingress: assert property (p_ingress) else $error("ingress filter ignored");
   property p_age_def;
      $rose(resetn_i) |-> age_reg == lfvf_pkg::AGE_DEF_S && ctrl_reg == 2'h0;
   endproperty
   a_age_def: assert property (p_age_def) else $error("wrong defaults after reset");
   property p_static_keep;
      (state_reg == S_AGE_WR && rd.valid && rd.stat) |-> !mem_we;
   endproperty
   a_static_keep: assert property (p_static_keep) else $error("static entry touched by aging");
   property p_age_out;
      (state_reg == S_AGE_WR && rd.valid && !rd.stat && 20'(rd.age + 20'h00001) >= age_reg) |-> mem_we && !wd.valid;
   endproperty
   a_age_out: assert property (p_age_out) else $error("stale entry kept");
endmodule // lfvf_engine

// file: rtl/lfvf_pkg.sv
// Constants and carrier types of the layer-2 forwarding and VLAN filter engine
package lfvf_pkg;
   localparam int unsigned CLK_FREQ_HZ = 50_000_000;
   localparam int unsigned AGE_UNIT_S  = 1;
   localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ * AGE_UNIT_S;
   localparam int unsigned FWD_DELAY_S = 15;
   localparam int unsigned NPORT       = 18;
   localparam int unsigned PORT_W      = 5;
   localparam int unsigned MAC_IG_BIT  = 40;
   localparam logic [19:0] AGE_MIN_S   = 20'h0000A;
   localparam logic [19:0] AGE_MAX_S   = 20'hF4240;
   localparam logic [19:0] AGE_DEF_S   = 20'h0012C;
   localparam logic [15:0] TPID_VLAN   = 16'h8100;
   localparam logic [11:0] VID_DEFAULT = 12'h001;
   localparam int unsigned CTRL_STP    = 0;
   localparam int unsigned CTRL_RAPID  = 1;
   localparam int unsigned CMD_ADD     = 8;
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_AGE     = 8'h04;
   localparam logic [7:0]  OFS_PRIM    = 8'h08;
   localparam logic [7:0]  OFS_STBY    = 8'h0C;
   localparam logic [7:0]  OFS_DPLX    = 8'h10;
   localparam logic [7:0]  OFS_EDGE    = 8'h14;
   localparam logic [7:0]  OFS_VSEL    = 8'h18;
   localparam logic [7:0]  OFS_VID     = 8'h1C;
   localparam logic [7:0]  OFS_VMEM    = 8'h20;
   localparam logic [7:0]  OFS_VUNT    = 8'h24;
   localparam logic [7:0]  OFS_PSEL    = 8'h28;
   localparam logic [7:0]  OFS_PVID    = 8'h2C;
   localparam logic [7:0]  OFS_MACLO   = 8'h30;
   localparam logic [7:0]  OFS_MACHI   = 8'h34;
   localparam logic [7:0]  OFS_CMD     = 8'h38;
   localparam logic [7:0]  OFS_BLK     = 8'h3C;
   localparam logic [7:0]  OFS_LINK    = 8'h40;

   typedef struct packed {
      logic [47:0]       dst;
      logic [47:0]       src;
      logic [15:0]       etype;
      logic [15:0]       tci;
      logic [PORT_W-1:0] port;
      logic              ctl;
   } lfvf_hdr_t;

   typedef struct packed {
      logic [NPORT-1:0] fwd;
      logic [NPORT-1:0] untag;
      logic [11:0]      vid;
      logic             ctl;
   } lfvf_dec_t;

   typedef struct packed {
      logic              valid;
      logic              stat;
      logic [PORT_W-1:0] port;
      logic [19:0]       age;
      logic [47:0]       mac;
   } lfvf_ent_t;
endpackage

// file: rtl/lfvf_table_ram.sv
// Station table memory: single port, registered read data
`timescale 1ns/1ps
module lfvf_table_ram #(
   parameter int unsigned WIDTH = 75,
   parameter int unsigned DEPTH = 256,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   input  wire logic             core_clk_i,
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    addr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   output logic      [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
   end
endmodule // lfvf_table_ram

// file: verification/lfvf_station_model.sv
// Station-side model: presents one frame header and holds it until the engine takes it
`timescale 1ns/1ps
module lfvf_station_model (
   input  wire logic                core_clk_i,
   input  wire logic                go_i,
   input  wire lfvf_pkg::lfvf_hdr_t hdr_i,
   input  wire logic                ready_i,
   output logic                     valid_o,
   output lfvf_pkg::lfvf_hdr_t      frame_o
);
   initial valid_o = 1'b0;
   initial frame_o = '0;
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk_i) begin
      if (valid_o && ready_i) begin
         valid_o <= 1'b0;
         // Released header inverted so a stale copy never looks like a fresh frame
         frame_o <= ~frame_o;
      end else if (go_i && !valid_o) begin
         valid_o <= 1'b1;
         frame_o <= hdr_i;
      end
   end
endmodule // lfvf_station_model

// file: verification/tb_lfvf_engine.sv
// Self-checking bench of the forwarding engine
`timescale 1ns/1ps
module tb_lfvf_engine;
   logic                   clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
   logic [7:0]             adr = 8'h00;
   logic [31:0]            wdat = 32'h0, rdat, q;
   logic                   ack, fv, fr, dv;
   logic [3:0]             sel = 4'hF;
   logic [17:0]            link = 18'h3FFFF;
   lfvf_pkg::lfvf_hdr_t    hdr = '0, fh;
   lfvf_pkg::lfvf_dec_t    dec;
   int                     err_total = 0, tests_run = 0;
   localparam logic [47:0] STA = 48'h02AABB000001;
   localparam logic [47:0] ALL = 48'h00000003FFFF;
   always #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   // Short tick and small table keep sweeps and clears brief
   lfvf_engine #(.DEPTH(16), .NVLAN(4), .TICK_CYCLES(2000), .FWD_DELAY_S(2)) u_dut (
      .core_clk_i(clk), .resetn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .frame_valid_i(fv), .frame_i(fh), .frame_ready_o(fr), .dec_valid_o(dv), .dec_o(dec),
      .link_up_i(link));
   lfvf_station_model u_sta (.core_clk_i(clk), .go_i(go), .hdr_i(hdr), .ready_i(fr), .valid_o(fv), .frame_o(fh));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) begin
         chk("bus timeout", 48'h1, 48'h0);
         results();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic send(input logic [47:0] d, input logic [47:0] s, input logic [15:0] tci, input logic [4:0] p,
                       input logic c, input logic tg);
      int n;
      n = 0;
      hdr <= '{dst: d, src: s, etype: (tg ? lfvf_pkg::TPID_VLAN : 16'h0800), tci: tci, port: p, ctl: c};
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      while (dv !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) begin
         chk("decision timeout", 48'h1, 48'h0);
         results();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, lfvf_pkg::OFS_CTRL, 32'h0);
      chk("ctrl", q, 48'h0);
      wb(1'b0, lfvf_pkg::OFS_AGE, 32'h0);
      chk("age default", q, 48'h12C);
      wb(1'b0, lfvf_pkg::OFS_PVID, 32'h0);
      chk("pvid", q, 48'h1);
      wb(1'b0, 8'h80, 32'h0);
      chk("unmapped", q, 48'h0);
      wb(1'b1, lfvf_pkg::OFS_AGE, 32'h00000005);
      wb(1'b0, lfvf_pkg::OFS_AGE, 32'h0);
      chk("age low", q, 48'h0000A);
      wb(1'b1, lfvf_pkg::OFS_AGE, 32'h02000000);
      wb(1'b0, lfvf_pkg::OFS_AGE, 32'h0);
      chk("age high", q, 48'hF4240);
      wb(1'b1, lfvf_pkg::OFS_AGE, 32'h0000012C);
      // Only the low byte lane may change
      sel <= 4'h1;
      wb(1'b1, lfvf_pkg::OFS_AGE, 32'hFFFFFF64);
      sel <= 4'hF;
      wb(1'b0, lfvf_pkg::OFS_AGE, 32'h0);
      chk("age byte lane", q, 48'h164);
      wb(1'b1, lfvf_pkg::OFS_AGE, 32'h0000012C);
      for (int n = 0; n < 200 && fr !== 1'b1; n++) @(posedge clk);
      chk("ready after clear", {47'h0, fr}, 48'h1);
      if (fr !== 1'b1) results();
      // Unknown unicast floods the default VLAN
      send(48'h02CCDD000009, STA, 16'h0000, 5'h03, 1'b0, 1'b0);
      chk("flood", {30'h0, dec.fwd}, ALL & ~48'h8);
      chk("untag", {30'h0, dec.untag}, ALL & ~48'h8);
      chk("vid", {36'h0, dec.vid}, 48'h1);
      // Learned station reached on its port only
      send(STA, 48'h02CCDD000005, 16'h0000, 5'h05, 1'b0, 1'b0);
      chk("known", {30'h0, dec.fwd}, 48'h8);
      send(STA, 48'h02CCDD000005, 16'h0001, 5'h05, 1'b0, 1'b1);
      chk("tagged", {30'h0, dec.fwd}, 48'h8);
      send(STA, 48'h02CCDD000005, 16'h0007, 5'h05, 1'b0, 1'b1);
      chk("foreign vlan", {30'h0, dec.fwd}, 48'h0);
      send(STA, 48'h02CCDD000005, 16'h0000, 5'h05, 1'b1, 1'b0);
      chk("control", {30'h0, dec.fwd}, 48'h0);
      chk("control flag", {47'h0, dec.ctl}, 48'h1);
      // Static station survives a learning attempt from another port
      wb(1'b1, lfvf_pkg::OFS_MACLO, 32'h00000011);
      wb(1'b1, lfvf_pkg::OFS_MACHI, 32'h000002EE);
      wb(1'b1, lfvf_pkg::OFS_CMD, 32'h00000102);
      send(STA, 48'h02EE00000011, 16'h0000, 5'h01, 1'b0, 1'b0);
      chk("known again", {30'h0, dec.fwd}, 48'h8);
      send(48'h02EE00000011, 48'h02CCDD000005, 16'h0000, 5'h00, 1'b0, 1'b0);
      chk("static", {30'h0, dec.fwd}, 48'h4);
      // Shrunk membership limits a broadcast
      wb(1'b1, lfvf_pkg::OFS_VMEM, 32'h0000000F);
      send(48'hFFFFFFFFFFFF, 48'h02CCDD000000, 16'h0000, 5'h00, 1'b0, 1'b0);
      chk("member flood", {30'h0, dec.fwd}, 48'hE);
      // Port 17 stands by for primary port 16
      wb(1'b1, lfvf_pkg::OFS_PRIM, 32'h00010000);
      wb(1'b1, lfvf_pkg::OFS_STBY, 32'h00020000);
      wb(1'b1, lfvf_pkg::OFS_DPLX, 32'h00020000);
      wb(1'b1, lfvf_pkg::OFS_CTRL, 32'h00000003);
      wb(1'b0, lfvf_pkg::OFS_BLK, 32'h0);
      chk("standby blocked", q, 48'h20000);
      link <= 18'h2FFFF;
      repeat (8) @(posedge clk);
      wb(1'b0, lfvf_pkg::OFS_BLK, 32'h0);
      chk("rapid failover", q, 48'h0);
      wb(1'b0, lfvf_pkg::OFS_LINK, 32'h0);
      chk("link state", q, 48'h2FFFF);
      // Legacy mode waits the forward delay before freeing the standby
      link <= 18'h3FFFF;
      wb(1'b1, lfvf_pkg::OFS_CTRL, 32'h00000001);
      repeat (8) @(posedge clk);
      wb(1'b0, lfvf_pkg::OFS_BLK, 32'h0);
      chk("reblocked", q, 48'h20000);
      link <= 18'h2FFFF;
      repeat (8) @(posedge clk);
      wb(1'b0, lfvf_pkg::OFS_BLK, 32'h0);
      chk("legacy hold", q, 48'h20000);
      repeat (6000) @(posedge clk);
      wb(1'b0, lfvf_pkg::OFS_BLK, 32'h0);
      chk("legacy failover", q, 48'h0);
      results();
   end
endmodule // tb_lfvf_engine
